// >>> rtl/qbgp_defs.svh
`ifndef QBGP_DEFS_SVH
`define QBGP_DEFS_SVH

// -----------------------------------------------------------------------------
// Register addresses in the special-function space
// -----------------------------------------------------------------------------
`define QBGP_ADDR_PORT_ONE   8'h90
`define QBGP_ADDR_PORT_THREE 8'hB0
`define QBGP_ADDR_PORT_FOUR  8'hC0
`define QBGP_ADDR_SEL1_LO    8'h8E
`define QBGP_ADDR_SEL1_HI    8'h8F
`define QBGP_ADDR_SEL3       8'h91
`define QBGP_ADDR_SEL4_LO    8'h92
`define QBGP_ADDR_SEL4_HI    8'h93

// -----------------------------------------------------------------------------
// Reset values and field layout
// -----------------------------------------------------------------------------
`define QBGP_LATCH_RST       8'hFF
`define QBGP_SEL_RST         8'h00
`define QBGP_BIT_HI          3'h7
`define QBGP_ZERO_BYTE       8'h00

`endif

// >>> rtl/qbgp_pin_cell.sv
`timescale 1ns/10ps
`include "qbgp_defs.svh"

module qbgp_pin_cell
    import qbgp_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       arst_n,
    input  wire logic       out_val,
    input  wire qbgp_mode_t mode,
    input  wire logic       pin_i,
    output logic            pin_sync,
    output logic            pull_dn,
    output logic            strong_up,
    output logic            weak_a_up,
    output logic            weak_b_up
);

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    logic s1_q, s1_d, s2_q, s2_d, dly_q, dly_d;
    logic pd_q, pd_d, su_q, su_d, wa_q, wa_d, wb_q, wb_d;

    always_comb begin
        s1_d  = pin_i;
        s2_d  = s1_q;
        dly_d = out_val;
        pd_d  = 1'b0;
        su_d  = 1'b0;
        wa_d  = 1'b0;
        wb_d  = 1'b0;
        case (mode)
            QBGP_MODE_QUASI: begin
                pd_d = ~out_val;
                su_d = out_val & ~dly_q;
                wb_d = out_val;
                wa_d = out_val & s2_q;
            end
            QBGP_MODE_INPUT: begin
                wb_d = 1'b1;
                wa_d = s2_q;
            end
            QBGP_MODE_OPEN: begin
                // No strong edge: a high output is held only by the weak pull-ups.
                pd_d = ~out_val;
                wb_d = out_val;
                wa_d = out_val & s2_q;
            end
            QBGP_MODE_PUSH: begin
                pd_d = ~out_val;
                su_d = out_val;
            end
            QBGP_MODE_ANALOG: begin
            end
            default: begin
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s1_q  <= 1'b1;
            s2_q  <= 1'b1;
            dly_q <= 1'b1;
            pd_q  <= 1'b0;
            su_q  <= 1'b0;
            wa_q  <= 1'b1;
            wb_q  <= 1'b1;
        end else begin
            s1_q  <= s1_d;
            s2_q  <= s2_d;
            dly_q <= dly_d;
            pd_q  <= pd_d;
            su_q  <= su_d;
            wa_q  <= wa_d;
            wb_q  <= wb_d;
        end
    end

    assign pin_sync  = s2_q;
    assign pull_dn   = pd_q;
    assign strong_up = su_q;
    assign weak_a_up = wa_q;
    assign weak_b_up = wb_q;

endmodule

// >>> rtl/qbgp_pkg.sv
package qbgp_pkg;

    // Drive mode of one pin, chosen by its function select bits.
    typedef enum logic [2:0] {
        QBGP_MODE_QUASI  = 3'h0,
        QBGP_MODE_INPUT  = 3'h1,
        QBGP_MODE_OPEN   = 3'h3,
        QBGP_MODE_PUSH   = 3'h2,
        QBGP_MODE_ANALOG = 3'h6
    } qbgp_mode_t;

endpackage

// >>> rtl/qbgp_ports.sv
// Operation
// - Three 8-bit ports, one latch per pin.
// - All pins are inputs during and after reset.
// - Each pin routes independently to its function.
// - Drive mode follows the selected function.
// - In quasi, open-drain and push-pull modes, writing 0 enables pull-down, releases pull-ups.
// - In quasi mode, writing 1 pulses strong pull-up one cycle; push-pull mode holds it on.
// - Pulse only on latch rise, via delayed copy.
// - Weak pull-ups stay on after the pulse.
// - Reset sets all port latches to ones.
// - Stronger weak pull-up drops when pin low.
// - Read-modify-write reads return latch contents.
// - Other reads return synchronised pin levels.
// - Single-bit writes leave other pins unchanged.
// - Bits read and write; non-RMW port reads return pins.
// - Function selects clear on reset.
`timescale 1ns/10ps
`include "qbgp_defs.svh"

module qbgp_ports
    import qbgp_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_wr,
    input  wire logic        sfr_bit_wr,
    input  wire logic [2:0]  sfr_bit_sel,
    input  wire logic [7:0]  sfr_wdata,
    input  wire logic        sfr_rd,
    input  wire logic        sfr_rmw,
    output logic      [7:0]  sfr_rdata,
    input  wire logic [23:0] pin_i,
    output logic      [23:0] pin_pull_dn,
    output logic      [23:0] pin_strong_up,
    output logic      [23:0] pin_weak_a_up,
    output logic      [23:0] pin_weak_b_up
);

    // -------------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------------
    // Byte or bit write into one register; a bit write touches one pin only.
    function automatic logic [7:0] wr_merge(input logic [7:0] cur, input logic hit);
        logic [7:0] r;
        r = cur;
        if (hit && sfr_wr) begin
            if (sfr_bit_wr) begin
                r[sfr_bit_sel] = sfr_wdata[0];
            end else begin
                r = sfr_wdata;
            end
        end
        return r;
    endfunction

    // -------------------------------------------------------------------------
    // Registers
    // -------------------------------------------------------------------------
    logic [7:0]  p1_q, p1_d, p3_q, p3_d, p4_q, p4_d;
    logic [7:0]  s1l_q, s1l_d, s1h_q, s1h_d, s3_q, s3_d, s4l_q, s4l_d, s4h_q, s4h_d;
    logic [7:0]  rd_q, rd_d;
    logic [23:0] lat, syn, pd, su, wa, wb;
    qbgp_mode_t  mode [24];

    assign lat = {p4_q, p3_q, p1_q};

    always_comb begin
        p1_d  = wr_merge(p1_q,  sfr_addr == `QBGP_ADDR_PORT_ONE);
        p3_d  = wr_merge(p3_q,  sfr_addr == `QBGP_ADDR_PORT_THREE);
        p4_d  = wr_merge(p4_q,  sfr_addr == `QBGP_ADDR_PORT_FOUR);
        s1l_d = wr_merge(s1l_q, sfr_addr == `QBGP_ADDR_SEL1_LO);
        s1h_d = wr_merge(s1h_q, sfr_addr == `QBGP_ADDR_SEL1_HI);
        s3_d  = wr_merge(s3_q,  sfr_addr == `QBGP_ADDR_SEL3);
        s4l_d = wr_merge(s4l_q, sfr_addr == `QBGP_ADDR_SEL4_LO);
        s4h_d = wr_merge(s4h_q, sfr_addr == `QBGP_ADDR_SEL4_HI);
        rd_d  = rd_q;
        if (sfr_rd) begin
            case (sfr_addr)
                `QBGP_ADDR_PORT_ONE:   rd_d = sfr_rmw ? p1_q : syn[7:0];
                `QBGP_ADDR_PORT_THREE: rd_d = sfr_rmw ? p3_q : syn[15:8];
                `QBGP_ADDR_PORT_FOUR:  rd_d = sfr_rmw ? p4_q : syn[23:16];
                `QBGP_ADDR_SEL1_LO:    rd_d = s1l_q;
                `QBGP_ADDR_SEL1_HI:    rd_d = s1h_q;
                `QBGP_ADDR_SEL3:       rd_d = s3_q;
                `QBGP_ADDR_SEL4_LO:    rd_d = s4l_q;
                `QBGP_ADDR_SEL4_HI:    rd_d = s4h_q;
                default:               rd_d = `QBGP_ZERO_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            p1_q  <= `QBGP_LATCH_RST;
            p3_q  <= `QBGP_LATCH_RST;
            p4_q  <= `QBGP_LATCH_RST;
            s1l_q <= `QBGP_SEL_RST;
            s1h_q <= `QBGP_SEL_RST;
            s3_q  <= `QBGP_SEL_RST;
            s4l_q <= `QBGP_SEL_RST;
            s4h_q <= `QBGP_SEL_RST;
            rd_q  <= `QBGP_ZERO_BYTE;
        end else begin
            p1_q  <= p1_d;
            p3_q  <= p3_d;
            p4_q  <= p4_d;
            s1l_q <= s1l_d;
            s1h_q <= s1h_d;
            s3_q  <= s3_d;
            s4l_q <= s4l_d;
            s4h_q <= s4h_d;
            rd_q  <= rd_d;
        end
    end

    // -------------------------------------------------------------------------
    // Per-pin mode selection
    // -------------------------------------------------------------------------
    // Peripheral output data is outside this block, so alternate outputs are
    // driven from the latch; the peripheral writes it through the same path.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!s1l_q[i])     mode[i] = QBGP_MODE_QUASI;
            else if (s1h_q[i]) mode[i] = (i < 2) ? QBGP_MODE_INPUT : QBGP_MODE_QUASI;
            else               mode[i] = QBGP_MODE_ANALOG;
            if (!s3_q[i])      mode[8 + i] = QBGP_MODE_QUASI;
            else if (i >= 6)   mode[8 + i] = QBGP_MODE_OPEN;
            else if (i >= 2)   mode[8 + i] = QBGP_MODE_INPUT;
            else               mode[8 + i] = QBGP_MODE_QUASI;
            if (!s4l_q[i])     mode[16 + i] = QBGP_MODE_QUASI;
            else if (s4h_q[i]) mode[16 + i] = QBGP_MODE_PUSH;
            else               mode[16 + i] = QBGP_MODE_QUASI;
        end
    end

    for (genvar g = 0; g < 24; g++) begin : g_pin
        qbgp_pin_cell u_cell (
            .ref_clk   (ref_clk),
            .arst_n    (arst_n),
            .out_val   (lat[g]),
            .mode      (mode[g]),
            .pin_i     (pin_i[g]),
            .pin_sync  (syn[g]),
            .pull_dn   (pd[g]),
            .strong_up (su[g]),
            .weak_a_up (wa[g]),
            .weak_b_up (wb[g])
        );
    end

    assign sfr_rdata     = rd_q;
    assign pin_pull_dn   = pd;
    assign pin_strong_up = su;
    assign pin_weak_a_up = wa;
    assign pin_weak_b_up = wb;

endmodule

// >>> sim/qbgp_pin_model.sv
`timescale 1ns/10ps
// ----------
// External devices on the pins
// ----------
module qbgp_pin_model (
    input  wire logic        ref_clk,
    input  wire logic [23:0] ext_low,
    input  wire logic [23:0] pull_dn,
    input  wire logic [23:0] up_any,
    output logic      [23:0] pin_i
);
    logic float_q = 1'b0;
    // An undriven pin toggles, so a stale level never passes for a held one.
    always @(posedge ref_clk) float_q <= ~float_q;
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            pin_i[i] = (pull_dn[i] || ext_low[i]) ? 1'b0 : (up_any[i] ? 1'b1 : float_q);
        end
    end
endmodule

// >>> sim/qbgp_ports_chk.sv
`timescale 1ns/10ps
// ----------
// Port checker
// ----------
module qbgp_ports_chk (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic [7:0]  sfr_addr,
    input wire logic        sfr_wr,
    input wire logic        sfr_bit_wr,
    input wire logic [7:0]  sfr_wdata,
    input wire logic        sfr_rd,
    input wire logic        sfr_rmw,
    input wire logic [7:0]  sfr_rdata,
    input wire logic [23:0] pin_i,
    input wire logic [23:0] pin_pull_dn,
    input wire logic [23:0] pin_strong_up,
    input wire logic [23:0] pin_weak_a_up,
    input wire logic [23:0] pin_weak_b_up
);
    // Port one is taken to stay in GPIO mode, since the selects are not visible here.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!arst_n);
    chk_reset_drive: assert property ($rose(arst_n) |-> pin_pull_dn == 24'h0
        && pin_weak_b_up == 24'hFFFFFF) else $error("bad drive after reset");
    chk_dn_vs_strong: assert property ((pin_pull_dn & pin_strong_up) == 24'h0)
        else $error("pull-down and strong pull-up together");
    chk_write_zero: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == 8'h90
        |=> ##1 pin_pull_dn[7:0] == ~$past(sfr_wdata, 2)) else $error("pull-down wrong");
    chk_rise_pulse: assert property (pin_strong_up[7:0] ==
        (~pin_pull_dn[7:0] & $past(pin_pull_dn[7:0]))) else $error("strong pulse wrong");
    chk_strong_once: assert property ((pin_strong_up[15:0] & $past(pin_strong_up[15:0]))
        == 16'h0) else $error("strong pull-up longer than one cycle");
    chk_weak_hold: assert property (pin_weak_b_up[7:0] == ~pin_pull_dn[7:0])
        else $error("weak pull-up wrong");
    chk_weak_a_drop: assert property ((pin_i[7:0] == 8'h00) [*5]
        |-> pin_weak_a_up[7:0] == 8'h00) else $error("pull-up A kept on low pin");
    chk_rmw_latch: assert property (sfr_wr && !sfr_bit_wr && sfr_addr == 8'h90 ##1
        sfr_rd && sfr_rmw && !sfr_wr && sfr_addr == 8'h90 |=> sfr_rdata == $past(sfr_wdata, 2))
        else $error("read-modify-write read wrong");
endmodule
bind qbgp_ports qbgp_ports_chk chk_u (.ref_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_bit_wr,
    .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_rdata, .pin_i, .pin_pull_dn, .pin_strong_up,
    .pin_weak_a_up, .pin_weak_b_up);

// >>> sim/qbgp_ports_tb.sv
`timescale 1ns/10ps
// ----------
// Port bench
// ----------
module qbgp_ports_tb;
    typedef struct {logic [7:0] addr, wdata, ext, pins;} qbgp_row_t;
    logic        ref_clk = 1'b0, arst_n = 1'b0, sfr_wr = 1'b0, sfr_bit_wr = 1'b0;
    logic        sfr_rd = 1'b0, sfr_rmw = 1'b0;
    logic [2:0]  sfr_bit_sel = 3'h0;
    logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, sfr_rdata;
    logic [23:0] pin_i, pull_dn, strong_up, weak_a, weak_b, ext_low = 24'h0;
    int          n_fail = 0, n_checks = 0;
    qbgp_row_t   rows [4] = '{'{8'h90, 8'hA5, 8'h0F, 8'hA0}, '{8'hB0, 8'h3C, 8'h00, 8'h3C},
                              '{8'hC0, 8'hFF, 8'h81, 8'h7E}, '{8'h90, 8'hFF, 8'hFF, 8'h00}};
    always #5 ref_clk = ~ref_clk;
    qbgp_ports dut_u (.ref_clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_bit_wr, .sfr_bit_sel,
        .sfr_wdata, .sfr_rd, .sfr_rmw, .sfr_rdata, .pin_i, .pin_pull_dn(pull_dn),
        .pin_strong_up(strong_up), .pin_weak_a_up(weak_a), .pin_weak_b_up(weak_b));
    qbgp_pin_model far_u (.ref_clk, .ext_low, .pull_dn, .up_any(strong_up | weak_a | weak_b),
        .pin_i);
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Tasks start and end at a falling edge; a write holds its strobe over one rising edge.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic bw);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_bit_wr = bw;
        sfr_wr = 1'b1;
        @(negedge ref_clk);
        sfr_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic rmw);
        sfr_addr = a;
        sfr_rmw = rmw;
        sfr_rd = 1'b1;
        @(negedge ref_clk);
        sfr_rd = 1'b0;
    endtask
    task automatic do_reset();
        arst_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        arst_n = 1'b1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        int k;
        do_reset();
        foreach (rows[i]) begin
            k = (rows[i].addr == 8'h90) ? 0 : ((rows[i].addr == 8'hB0) ? 1 : 2);
            ext_low[8*k +: 8] = rows[i].ext;
            wr(rows[i].addr, rows[i].wdata, 1'b0);
            rd(rows[i].addr, 1'b1);
            check("latch", sfr_rdata, rows[i].wdata);
            check("pull-down", pull_dn[8*k +: 8], ~rows[i].wdata);
            repeat (3) @(negedge ref_clk);
            rd(rows[i].addr, 1'b0);
            check("pins", sfr_rdata, rows[i].pins);
            check("pull-up a", weak_a[8*k +: 8], rows[i].wdata & rows[i].pins);
            $display("row %0d done", i);
            @(negedge ref_clk);
        end
        ext_low = 24'h0;
        wr(8'h90, 8'h00, 1'b0);
        @(negedge ref_clk);
        wr(8'h90, 8'hFF, 1'b0);
        @(negedge ref_clk);
        check("pulse", strong_up[7:0], 8'hFF);
        @(negedge ref_clk);
        check("pulse end", strong_up[7:0], 8'h00);
        check("weak hold", weak_b[7:0], 8'hFF);
        wr(8'h90, 8'hFF, 1'b0);
        @(negedge ref_clk);
        check("no pulse", strong_up[7:0], 8'h00);
        $display("pulse test done");
        sfr_bit_sel = 3'h3;
        wr(8'h90, 8'h00, 1'b1);
        rd(8'h90, 1'b1);
        check("bit write", sfr_rdata, 8'hF7);
        wr(8'hB0, 8'h00, 1'b0);
        @(negedge ref_clk);
        wr(8'h91, 8'h40, 1'b0);
        @(negedge ref_clk);
        wr(8'hB0, 8'hFF, 1'b0);
        @(negedge ref_clk);
        check("open drain", strong_up[15:8], 8'hBF);
        wr(8'hA0, 8'h55, 1'b0);
        rd(8'hA0, 1'b0);
        check("unmapped", sfr_rdata, 8'h00);
        wr(8'h92, 8'h01, 1'b0);
        @(negedge ref_clk);
        wr(8'h93, 8'h01, 1'b0);
        @(negedge ref_clk);
        wr(8'hC0, 8'hFE, 1'b0);
        repeat (2) @(negedge ref_clk);
        check("push low", pull_dn[23:16], 8'h01);
        wr(8'hC0, 8'hFF, 1'b0);
        repeat (3) @(negedge ref_clk);
        check("push high", strong_up[23:16], 8'h01);
        $display("mode test done");
        do_reset();
        check("reset drive", pull_dn[7:0] | pull_dn[15:8] | pull_dn[23:16], 8'h00);
        rd(8'h90, 1'b1);
        check("reset latch", sfr_rdata, 8'hFF);
        rd(8'h91, 1'b0);
        check("reset select", sfr_rdata, 8'h00);
        $display("reset test done");
        report_and_stop();
    end
endmodule
